// file: bench/scss_osc_model.sv
// Oscillator source model: levels toggle only while powered
`timescale 1ns/100ps
module scss_osc_model #(
	parameter int PRIM_HALF = 1,
	parameter int SEC_HALF  = 3,
	parameter int SLOW_HALF = 2
) (
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	input  wire scss_pkg::scss_clk_ctl_s clkCtl,
	output      logic                    primClkLvl,
	output      logic                    secClkLvl,
	output      logic                    slowClkLvl
);
	int pCnt;
	int sCnt;
	int lCnt;
	// A stopped source sits low; stopping it while high supplies one last falling edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{primClkLvl, secClkLvl, slowClkLvl} <= 3'h0;
			{pCnt, sCnt, lCnt} <= '0;
		end else begin
			pCnt <= (pCnt >= PRIM_HALF - 1) ? 0 : pCnt + 1;
			sCnt <= (sCnt >= SEC_HALF - 1) ? 0 : sCnt + 1;
			lCnt <= (lCnt >= SLOW_HALF - 1) ? 0 : lCnt + 1;
			primClkLvl <= clkCtl.primOscEn & (primClkLvl ^ (pCnt >= PRIM_HALF - 1));
			secClkLvl <= clkCtl.secOscEn & (secClkLvl ^ (sCnt >= SEC_HALF - 1));
			slowClkLvl <= clkCtl.slowOscEn & (slowClkLvl ^ (lCnt >= SLOW_HALF - 1));
		end
	end
endmodule // scss_osc_model

// file: bench/system_clock_switch_sequencer_tb.sv
// Self-checking bench: register accesses and clock switch sequences
`timescale 1ns/100ps
module system_clock_switch_sequencer_tb;
	logic                    clk;
	logic                    arst_n;
	scss_pkg::scss_wb_req_s  wbReq;
	scss_pkg::scss_wb_rsp_s  wbRsp;
	scss_pkg::scss_pmode_e   primMode;
	logic                    twoSpeedEn;
	logic                    fastOscSelected;
	logic                    wdtUsesSlow;
	logic                    fscmUsesSlow;
	logic                    primClkLvl;
	logic                    secClkLvl;
	logic                    slowClkLvl;
	scss_pkg::scss_clk_ctl_s clkCtl;
	logic [31:0]             rd;
	int                      miscompares;
	int                      nChecks;
	int                      cyc;
	int                      t0;

	scss_top #(.STABLE_DLY_CYC(20)) scss_top_i (.clk(clk), .arst_n(arst_n),
		.wbReq(wbReq), .wbRsp(wbRsp), .primMode(primMode), .twoSpeedEn(twoSpeedEn),
		.primClkLvl(primClkLvl), .secClkLvl(secClkLvl), .slowClkLvl(slowClkLvl),
		.fastOscSelected(fastOscSelected), .wdtUsesSlow(wdtUsesSlow),
		.fscmUsesSlow(fscmUsesSlow), .clkCtl(clkCtl));
	scss_osc_model scss_osc_model_i (.clk(clk), .arst_n(arst_n), .clkCtl(clkCtl),
		.primClkLvl(primClkLvl), .secClkLvl(secClkLvl), .slowClkLvl(slowClkLvl));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		nChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chkIn(input string nm, input int lo, input int hi, input int got);
		nChecks++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask

	// Holds the request until ack is sampled; read data is taken at that edge
	task automatic wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (wbRsp.ack !== 1'b1 && k < 50);
		chk("wbAck", 32'h1, {31'h0, wbRsp.ack});
		rd = wbRsp.dat;
		wbReq <= '0;
	endtask

	task automatic waitCtl(input logic onHold, input logic [1:0] v);
		int k;
		k = 0;
		while ((onHold ? {1'b0, clkCtl.coreHold} : clkCtl.sysClkSel) !== v && k < 5000) begin
			@(posedge clk);
			k++;
		end
		chk(onHold ? "coreHold" : "sysClkSel", {30'h0, v},
			{30'h0, onHold ? {1'b0, clkCtl.coreHold} : clkCtl.sysClkSel});
	endtask

	task automatic doReset(input scss_pkg::scss_pmode_e m, input logic ts);
		@(posedge clk);
		arst_n <= 1'b0;
		primMode <= m;
		twoSpeedEn <= ts;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		t0 = cyc + 1;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		arst_n = 1'b0;
		wbReq = '0;
		primMode = scss_pkg::PM_XTAL_STD;
		twoSpeedEn = 1'b0;
		fastOscSelected = 1'b1;
		wdtUsesSlow = 1'b0;
		fscmUsesSlow = 1'b0;
		cyc = 0;
		miscompares = 0;
		nChecks = 0;
		doReset(scss_pkg::PM_XTAL_STD, 1'b0);
		wbXfer(1'b0, scss_pkg::STATUS_ADR, '0);
		chk("status", 32'h0c, rd & 32'h3f);
		wbXfer(1'b0, scss_pkg::OSC_CTRL_ADR, '0);
		chk("oscCtrl", 32'h0, rd);
		waitCtl(1'b1, 2'h0);
		chkIn("bootHold", 2045, 2058, cyc - t0);
		wbXfer(1'b0, scss_pkg::OSC_CTRL_ADR, '0);
		chk("primActive", 32'h8, rd & 32'hb);
		$display("test boot done");
		wbXfer(1'b1, scss_pkg::SEC_CTRL_ADR, 32'h1);
		wbXfer(1'b1, scss_pkg::OSC_CTRL_ADR, 32'h1);
		t0 = cyc;
		waitCtl(1'b0, 2'h1);
		chk("ctlSec", 32'h1a, {26'h0, clkCtl});
		wbXfer(1'b0, scss_pkg::OSC_CTRL_ADR, '0);
		chk("primFlagOff", 32'h0, rd & 32'h8);
		waitCtl(1'b1, 2'h0);
		chkIn("secHold", 46, 62, cyc - t0);
		wbXfer(1'b0, scss_pkg::SEC_CTRL_ADR, '0);
		chk("secCtrl", 32'h3, rd);
		$display("test secondary done");
		wbXfer(1'b1, scss_pkg::SEC_CTRL_ADR, 32'h0);
		t0 = cyc;
		wbXfer(1'b0, scss_pkg::OSC_CTRL_ADR, '0);
		chk("selCleared", 32'h0, rd & 32'h3);
		chk("ctlOst", 32'h16, {26'h0, clkCtl});
		wbXfer(1'b1, scss_pkg::OSC_CTRL_ADR, 32'h2);
		waitCtl(1'b0, 2'h0);
		chkIn("ostTime", 2040, 2070, cyc - t0);
		waitCtl(1'b1, 2'h0);
		chk("secStopped", 32'h0, {31'h0, clkCtl.secOscEn});
		waitCtl(1'b0, 2'h2);
		wbXfer(1'b0, scss_pkg::OSC_CTRL_ADR, '0);
		chk("notStable", 32'h0, rd & 32'h4);
		repeat (40) @(posedge clk);
		wbXfer(1'b0, scss_pkg::OSC_CTRL_ADR, '0);
		chk("stable", 32'h4, rd & 32'h4);
		$display("test return done");
		wbXfer(1'b1, scss_pkg::OSC_CTRL_ADR, 32'h3);
		repeat (20) @(posedge clk);
		chk("reserved", 32'h2, {30'h0, clkCtl.sysClkSel});
		wdtUsesSlow <= 1'b1;
		wbXfer(1'b1, scss_pkg::OSC_CTRL_ADR, 32'h0);
		waitCtl(1'b0, 2'h0);
		waitCtl(1'b1, 2'h0);
		chk("slowKept", 32'h1, {31'h0, clkCtl.slowOscEn});
		wdtUsesSlow <= 1'b0;
		fscmUsesSlow <= 1'b1;
		repeat (2) @(posedge clk);
		chk("slowMonitor", 32'h1, {31'h0, clkCtl.slowOscEn});
		fscmUsesSlow <= 1'b0;
		repeat (2) @(posedge clk);
		chk("slowOff", 32'h0, {31'h0, clkCtl.slowOscEn});
		wbXfer(1'b0, 8'h0c, '0);
		chk("unmapped", 32'h0, rd);
		$display("test internal done");
		doReset(scss_pkg::PM_EXT_CLOCK, 1'b0);
		waitCtl(1'b1, 2'h0);
		chkIn("extBoot", 250, 264, cyc - t0);
		wbXfer(1'b1, scss_pkg::SEC_CTRL_ADR, 32'h1);
		wbXfer(1'b1, scss_pkg::OSC_CTRL_ADR, 32'h1);
		waitCtl(1'b0, 2'h1);
		waitCtl(1'b1, 2'h0);
		wbXfer(1'b1, scss_pkg::OSC_CTRL_ADR, 32'h0);
		t0 = cyc;
		waitCtl(1'b0, 2'h0);
		waitCtl(1'b1, 2'h0);
		chkIn("extReturn", 262, 280, cyc - t0);
		$display("test external boot done");
		doReset(scss_pkg::PM_XTAL_HIGH, 1'b1);
		repeat (4) @(posedge clk);
		chk("twoSpeed", 32'h4, {29'h0, clkCtl.sysClkSel, clkCtl.coreHold});
		waitCtl(1'b0, 2'h0);
		chkIn("twoSpeedOst", 2045, 2062, cyc - t0);
		$display("test two speed done");
		test_done();
	end

	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		$display("[ERR] watchdog expected finish seen hang");
		test_done();
	end
endmodule // system_clock_switch_sequencer_tb

// file: logic/scss_pkg.sv
// Package: constants, carriers and helpers of the system clock switch sequencer
// Behaviour
// - Select secondary: clear primary flag, switch, stop primary.
// - Hold phase one for eight secondary falling edges.
// - Secondary running flag set only while secondary clocks.
// - Crystal return waits 1024 primary start-up edges.
// - Keep running on old clock during start-up count.
// - Primary active flag set when primary takes over.
// - Hold phase one for eight primary falling edges.
// - Clearing secondary enable in secondary run clears select bit0.
// - Secondary stays running until the switch completes.
// - External clock or resistor-cap return adds 5-10 us delay.
// - Non-crystal primary skips the start-up count.
// - Stop slow internal oscillator unless watchdog or monitor use it.
// - Secondary kept running while its enable is set, while it is current, or while it is the switch target.
// - Reset clears select to 00, defaults to primary.
// - Crystal boot holds core for 1024 primary edges.
// - Two-speed boot runs from slow internal oscillator meanwhile.
// - Non-crystal boot holds phase one for 5-10 us.
// - Both start-up timers done, then one more cycle.
// - Fast internal oscillator stable flag set 4 ms later.
// - Select codes: 00 primary, 01 secondary, 10 internal, 11 reserved.
package scss_pkg;

	localparam int          CLK_HZ         = 50_000_000;
	localparam int          CLK_PERIOD_NS  = 20;

	// Register byte addresses and field positions
	localparam logic [7:0]  OSC_CTRL_ADR   = 8'h00;
	localparam logic [7:0]  SEC_CTRL_ADR   = 8'h04;
	localparam logic [7:0]  STATUS_ADR     = 8'h08;
	localparam int          OSC_SEL_LSB    = 0;
	localparam int          OSC_STABLE_BIT = 2;
	localparam int          OSC_PRIMACT_BIT = 3;
	localparam int          SEC_EN_BIT     = 0;
	localparam int          SECONDARY_RUN_STATE_BIT    = 1;
	localparam int          ST_SYSCLK_LSB  = 0;
	localparam int          ST_HOLD_BIT    = 2;
	localparam int          ST_PRIMEN_BIT  = 3;
	localparam int          ST_SECEN_BIT   = 4;
	localparam int          ST_SLOWEN_BIT  = 5;
	localparam int          ST_BUSY_BIT    = 6;

	// Clock select codes
	localparam logic [1:0]  SEL_PRIMARY    = 2'h0;
	localparam logic [1:0]  SEL_SECONDARY  = 2'h1;
	localparam logic [1:0]  SEL_INTERNAL   = 2'h2;
	localparam logic [1:0]  SEL_RESERVED   = 2'h3;

	// Counts and times
	localparam logic [10:0] OST_EDGES      = 11'h400;
	localparam logic [3:0]  HOLD_EDGES     = 4'h8;
	localparam logic [11:0] CPU_START_CYC  = 12'h100;
	localparam int          INT_DLY_NS     = 5000;
	localparam int          INT_DLY_CYC_I  = (INT_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [8:0]  INT_DLY_CYC    = 9'(INT_DLY_CYC_I);
	localparam int          STABLE_DLY_MS  = 4;
	localparam int          STABLE_DLY_CYC = STABLE_DLY_MS * (CLK_HZ / 1000);

	typedef enum logic [2:0] {
		PM_XTAL_LOW,
		PM_XTAL_STD,
		PM_XTAL_HIGH,
		PM_EXT_CLOCK,
		PM_EXT_RESCAP,
		PM_INT_SLOW
	} scss_pmode_e;

	typedef enum logic [2:0] {
		ST_BOOT,
		ST_BOOT_LAST,
		ST_RUN,
		ST_OST,
		ST_HOLD,
		ST_DELAY
	} scss_state_e;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} scss_wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} scss_wb_rsp_s;

	typedef struct packed {
		logic [1:0] sysClkSel;
		logic       coreHold;
		logic       primOscEn;
		logic       secOscEn;
		logic       slowOscEn;
	} scss_clk_ctl_s;

	typedef struct packed {
		scss_state_e state;
		logic [1:0]  cur;
		logic [1:0]  tgt;
		logic [1:0]  sel;
		logic        secEnable;
		logic        primActive;
		logic        secRunning;
		logic        freqStable;
		logic        stableRun;
		logic [10:0] startCnt;
		logic [11:0] cpuCnt;
		logic [3:0]  edgeCnt;
		logic [8:0]  dlyCnt;
		logic [17:0] stableCnt;
		logic        primPrev;
		logic        secPrev;
		logic        slowPrev;
		logic [1:0]  sysClk;
		logic        coreHold;
		logic        primOscEn;
		logic        secOscEn;
		logic        slowOscEn;
		logic        ack;
		logic [31:0] rdat;
	} scss_state_s;

	localparam scss_state_s STATE_RST = '{
		state:     ST_BOOT,
		coreHold:  1'b1,
		primOscEn: 1'b1,
		default:   '0
	};

	function automatic logic isXtal(input scss_pmode_e m);
		return (m == PM_XTAL_LOW) || (m == PM_XTAL_STD) || (m == PM_XTAL_HIGH);
	endfunction

endpackage

// file: logic/scss_top.sv
// System clock switch sequencer with Wishbone register access
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
module scss_top #(
	parameter int STABLE_DLY_CYC = scss_pkg::STABLE_DLY_CYC
) (
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	input  wire scss_pkg::scss_wb_req_s wbReq,
	output      scss_pkg::scss_wb_rsp_s wbRsp,
	input  wire scss_pkg::scss_pmode_e  primMode,
	input  wire logic                  twoSpeedEn,
	input  wire logic                  primClkLvl,
	input  wire logic                  secClkLvl,
	input  wire logic                  slowClkLvl,
	input  wire logic                  fastOscSelected,
	input  wire logic                  wdtUsesSlow,
	input  wire logic                  fscmUsesSlow,
	output      scss_pkg::scss_clk_ctl_s clkCtl
);

	scss_pkg::scss_state_s r;
	scss_pkg::scss_state_s n;

	logic primFall;
	logic secFall;
	logic slowFall;
	logic holdFall;
	logic xtal;
	logic busy;
	logic wbTake;
	logic wbWrite;
	logic wbWrSecClr;
	logic ostDone;
	logic cpuDone;
	logic dlyDone;

	always_comb begin
		n          = r;
		xtal       = scss_pkg::isXtal(primMode);
		primFall   = r.primPrev & ~primClkLvl;
		secFall    = r.secPrev & ~secClkLvl;
		slowFall   = r.slowPrev & ~slowClkLvl;
		n.primPrev = primClkLvl;
		n.secPrev  = secClkLvl;
		n.slowPrev = slowClkLvl;
		case (r.tgt)
			scss_pkg::SEL_PRIMARY:   holdFall = primFall;
			scss_pkg::SEL_SECONDARY: holdFall = secFall;
			default:                 holdFall = slowFall;
		endcase
		ostDone = (r.startCnt == scss_pkg::OST_EDGES);
		cpuDone = (r.cpuCnt == scss_pkg::CPU_START_CYC);
		dlyDone = (r.dlyCnt == scss_pkg::INT_DLY_CYC);

		// Bus: ack one cycle after the request, write lands on the ack edge
		wbTake     = wbReq.cyc & wbReq.stb & ~r.ack;
		wbWrite    = wbReq.cyc & wbReq.stb & r.ack & wbReq.we & wbReq.sel[0];
		wbWrSecClr = wbWrite & (wbReq.adr == scss_pkg::SEC_CTRL_ADR)
			& ~wbReq.dat[scss_pkg::SEC_EN_BIT];
		n.ack      = wbTake;
		if (wbTake) begin
			n.rdat = 32'h0;
			case (wbReq.adr)
				scss_pkg::OSC_CTRL_ADR: begin
					n.rdat[scss_pkg::OSC_SEL_LSB +: 2]   = r.sel;
					n.rdat[scss_pkg::OSC_STABLE_BIT]     = r.freqStable;
					n.rdat[scss_pkg::OSC_PRIMACT_BIT]    = r.primActive;
				end
				scss_pkg::SEC_CTRL_ADR: begin
					n.rdat[scss_pkg::SEC_EN_BIT]         = r.secEnable;
					n.rdat[scss_pkg::SECONDARY_RUN_STATE_BIT]        = r.secRunning;
				end
				scss_pkg::STATUS_ADR: begin
					n.rdat[scss_pkg::ST_SYSCLK_LSB +: 2] = r.sysClk;
					n.rdat[scss_pkg::ST_HOLD_BIT]        = r.coreHold;
					n.rdat[scss_pkg::ST_PRIMEN_BIT]      = r.primOscEn;
					n.rdat[scss_pkg::ST_SECEN_BIT]       = r.secOscEn;
					n.rdat[scss_pkg::ST_SLOWEN_BIT]      = r.slowOscEn;
					n.rdat[scss_pkg::ST_BUSY_BIT]        = (r.state != scss_pkg::ST_RUN);
				end
				default: n.rdat = 32'h0;
			endcase
		end
		if (wbWrite && wbReq.adr == scss_pkg::OSC_CTRL_ADR) begin
			n.sel = wbReq.dat[scss_pkg::OSC_SEL_LSB +: 2];
		end
		if (wbWrite && wbReq.adr == scss_pkg::SEC_CTRL_ADR) begin
			n.secEnable = wbReq.dat[scss_pkg::SEC_EN_BIT];
			if (wbWrSecClr && r.cur == scss_pkg::SEL_SECONDARY) begin
				n.sel[0] = 1'b0;
			end
		end

		// Fast internal oscillator settling timer
		if (r.stableRun) begin
			n.stableCnt = r.stableCnt + 18'h1;
			if (r.stableCnt == 18'(STABLE_DLY_CYC - 1)) begin
				n.freqStable = 1'b1;
				n.stableRun  = 1'b0;
			end
		end

		case (r.state)
			scss_pkg::ST_BOOT: begin
				// Start-up and CPU timers run side by side
				if (!ostDone && primFall) begin
					n.startCnt = r.startCnt + 11'h1;
				end
				if (!cpuDone) begin
					n.cpuCnt = r.cpuCnt + 12'h1;
				end
				if (!dlyDone) begin
					n.dlyCnt = r.dlyCnt + 9'h1;
				end
				if (xtal && twoSpeedEn) begin
					n.sysClk   = scss_pkg::SEL_INTERNAL;
					n.coreHold = 1'b0;
				end else begin
					n.sysClk   = scss_pkg::SEL_PRIMARY;
					n.coreHold = 1'b1;
				end
				if (cpuDone && (xtal ? ostDone : dlyDone)) begin
					n.state = scss_pkg::ST_BOOT_LAST;
				end
			end
			scss_pkg::ST_BOOT_LAST: begin
				n.sysClk     = scss_pkg::SEL_PRIMARY;
				n.coreHold   = 1'b0;
				n.primActive = 1'b1;
				n.state      = scss_pkg::ST_RUN;
			end
			scss_pkg::ST_RUN: begin
				// Pending writes are seen here only once a transition ends
				if (r.sel != scss_pkg::SEL_RESERVED && r.sel != r.cur) begin
					n.tgt     = r.sel;
					n.edgeCnt = 4'h0;
					n.dlyCnt  = 9'h0;
					case (r.sel)
						scss_pkg::SEL_SECONDARY: begin
							n.primActive = 1'b0;
							n.sysClk     = scss_pkg::SEL_SECONDARY;
							n.coreHold   = 1'b1;
							n.state      = scss_pkg::ST_HOLD;
						end
						scss_pkg::SEL_INTERNAL: begin
							if (primMode == scss_pkg::PM_INT_SLOW &&
								r.cur == scss_pkg::SEL_PRIMARY) begin
								n.cur = scss_pkg::SEL_INTERNAL;
							end else begin
								n.primActive = 1'b0;
								n.sysClk     = scss_pkg::SEL_INTERNAL;
								n.coreHold   = 1'b1;
								n.state      = scss_pkg::ST_HOLD;
								if (fastOscSelected) begin
									n.freqStable = 1'b0;
									n.stableRun  = 1'b1;
									n.stableCnt  = 18'h0;
								end
							end
						end
						default: begin
							if (xtal) begin
								n.startCnt = 11'h0;
								n.state    = scss_pkg::ST_OST;
							end else begin
								n.sysClk     = scss_pkg::SEL_PRIMARY;
								n.primActive = 1'b1;
								n.coreHold   = 1'b1;
								n.state      = scss_pkg::ST_HOLD;
							end
						end
					endcase
				end
			end
			scss_pkg::ST_OST: begin
				// Old clock keeps the core going while the crystal starts
				if (!ostDone && primFall) begin
					n.startCnt = r.startCnt + 11'h1;
				end
				if (ostDone) begin
					n.sysClk     = scss_pkg::SEL_PRIMARY;
					n.primActive = 1'b1;
					n.coreHold   = 1'b1;
					n.state      = scss_pkg::ST_HOLD;
				end
			end
			scss_pkg::ST_HOLD: begin
				if (holdFall) begin
					n.edgeCnt = r.edgeCnt + 4'h1;
				end
				if (holdFall && r.edgeCnt == scss_pkg::HOLD_EDGES - 4'h1) begin
					if (r.tgt == scss_pkg::SEL_PRIMARY && !xtal &&
						primMode != scss_pkg::PM_INT_SLOW) begin
						n.state = scss_pkg::ST_DELAY;
					end else begin
						n.coreHold = 1'b0;
						n.cur      = r.tgt;
						n.state    = scss_pkg::ST_RUN;
					end
				end
			end
			scss_pkg::ST_DELAY: begin
				n.dlyCnt = r.dlyCnt + 9'h1;
				if (r.dlyCnt == scss_pkg::INT_DLY_CYC - 9'h1) begin
					n.coreHold = 1'b0;
					n.cur      = r.tgt;
					n.state    = scss_pkg::ST_RUN;
				end
			end
			default: n.state = scss_pkg::ST_RUN;
		endcase

		busy = (n.state != scss_pkg::ST_RUN);
		// Flag follows the actual clock, not the select field
		n.secRunning = (n.sysClk == scss_pkg::SEL_SECONDARY) & ~n.coreHold;
		n.primOscEn  = (n.sysClk == scss_pkg::SEL_PRIMARY) |
			(busy & (n.tgt == scss_pkg::SEL_PRIMARY)) |
			(n.state == scss_pkg::ST_BOOT) | (n.state == scss_pkg::ST_BOOT_LAST);
		// Secondary lives on until the switch-away completes
		n.secOscEn   = n.secEnable | (n.cur == scss_pkg::SEL_SECONDARY) |
			(busy & (n.tgt == scss_pkg::SEL_SECONDARY));
		n.slowOscEn  = (n.sysClk == scss_pkg::SEL_INTERNAL) |
			(n.cur == scss_pkg::SEL_INTERNAL) | (primMode == scss_pkg::PM_INT_SLOW) |
			wdtUsesSlow | fscmUsesSlow;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= scss_pkg::STATE_RST;
		end else begin
			r <= n;
		end
	end

	assign wbRsp  = '{ack: r.ack, dat: r.rdat};
	assign clkCtl = '{sysClkSel: r.sysClk, coreHold: r.coreHold, primOscEn: r.primOscEn,
		secOscEn: r.secOscEn, slowOscEn: r.slowOscEn};

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_sec_entry: assert property (
		(r.state == scss_pkg::ST_RUN && r.sel == scss_pkg::SEL_SECONDARY &&
		 r.cur != scss_pkg::SEL_SECONDARY)
		|=> (r.sysClk == scss_pkg::SEL_SECONDARY && !r.primActive && r.coreHold &&
		 !r.primOscEn)) else $error("secondary entry not taken");

	a_hold_release: assert property (
		(r.state == scss_pkg::ST_HOLD && r.tgt == scss_pkg::SEL_SECONDARY &&
		 r.edgeCnt == 4'h7 && secFall)
		|=> (!r.coreHold && r.secRunning && r.state == scss_pkg::ST_RUN))
		else $error("secondary hold not released on eighth edge");

	a_sec_flag: assert property (
		r.secRunning |-> (r.sysClk == scss_pkg::SEL_SECONDARY))
		else $error("secondary flag without secondary clock");

	a_ost_keep: assert property (
		(r.state == scss_pkg::ST_OST) |-> (!r.coreHold && !r.primActive &&
		 r.sysClk != scss_pkg::SEL_PRIMARY && r.primOscEn))
		else $error("core stalled during start-up count");

	a_prim_flag: assert property (
		$rose(r.primActive) |-> (r.sysClk == scss_pkg::SEL_PRIMARY))
		else $error("primary flag set on other clock");

	a_enable_clear: assert property (
		(wbWrSecClr && r.cur == scss_pkg::SEL_SECONDARY) |=> !r.sel[0])
		else $error("select bit0 not cleared");

	a_delay_hold: assert property (
		$rose(r.state == scss_pkg::ST_DELAY)
		|-> (r.state == scss_pkg::ST_DELAY && r.coreHold)[*8])
		else $error("internal delay cut short");

	a_slow_keep: assert property (
		(wdtUsesSlow || fscmUsesSlow) |=> r.slowOscEn)
		else $error("slow oscillator stopped while in use");

	a_boot_hold: assert property (
		(r.state == scss_pkg::ST_BOOT && !twoSpeedEn && xtal && r.startCnt != 11'h0)
		|-> r.coreHold) else $error("crystal boot not held");

	a_boot_last: assert property (
		(r.state == scss_pkg::ST_BOOT_LAST)
		|-> ($past(r.state) == scss_pkg::ST_BOOT ##1
		 (r.state == scss_pkg::ST_RUN && !r.coreHold && r.primActive)))
		else $error("boot extra cycle wrong");

	a_reserved_sel: assert property (
		(r.state == scss_pkg::ST_RUN && r.sel == scss_pkg::SEL_RESERVED)
		|=> (r.state == scss_pkg::ST_RUN && $stable(r.sysClk)))
		else $error("reserved select acted on");

	a_ack_pulse: assert property (
		r.ack |=> !r.ack) else $error("ack held two cycles");

endmodule // scss_top
